/* inc/eeprom_pkg.sv */
// Shared constants, command codes and helpers for the serial memory link
// Contract
// - Latch flag must be set before any write
// - Opcode 06h sets latch at select release
// - Latch flag is zero after power-up
// - Master holds write guard high during set
// - Opcode 04h clears latch regardless of guard
// - Status write changes only protect bits 3:2
// - Protect bits are nonvolatile, kept across reset
// - Valid write starts timed cycle at release
// - During write cycle only status read works
// - Write cycle completion clears latch flag
// - Protect levels: none, quarter, half, all
// - Read is 03h plus address byte
// - Address width follows array size
// - After address, data shifts out MSB first
// - Read address increments and wraps to zero
// - Write ignored if guard low or latch clear
// - Protected locations are never programmed
// - Write is 02h, address, data; program at release
// - Master releases select right after last bit
// - Bad opcode mutes output until next select
// - Opcode 05h returns status byte MSB first
// - Status: busy bit0, latch bit1, 7:4 busy
// - Up to 8 bytes, low three bits wrap
package eeprom_pkg;
	// ****************************************
	// Command codes and status layout
	// ****************************************
	localparam logic [7:0] OP_LATCH_SET = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam int OP_TOP_BIT = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_PROT_LSB = 2;
	localparam logic [1:0] PROT_FACTORY = 2'h0;
	localparam int PAGE_BYTES = 8;
	localparam int ADDR_W_DEF = 9;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int T_WC_NS = 5_000_000;
	localparam int WC_CYCLES = T_WC_NS / CLK_NS;
	localparam int T_SCK_NS = 125;
	localparam int SCK_HALF_CYC = (T_SCK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
	// ****************************************
	// Commands
	// ****************************************
	typedef enum logic [2:0] {
		CMD_BAD, CMD_SET, CMD_CLR, CMD_SRD, CMD_SWR, CMD_READ, CMD_WRITE
	} cmd_e;
	function automatic cmd_e decode_cmd(input logic [7:0] op);
		cmd_e c;
		c = CMD_BAD;
		if (op[7:4] == 4'h0) begin
			unique case (op[2:0])
				OP_LATCH_SET[2:0]: c = CMD_SET;
				OP_LATCH_CLR[2:0]: c = CMD_CLR;
				OP_STAT_RD[2:0]: c = CMD_SRD;
				OP_STAT_WR[2:0]: c = CMD_SWR;
				OP_READ[2:0]: c = CMD_READ;
				OP_WRITE[2:0]: c = CMD_WRITE;
				default: c = CMD_BAD;
			endcase
		end
		return c;
	endfunction
	// Block protection by the two top address bits
	function automatic logic is_protected(input logic [8:0] a,
		input logic [1:0] lvl, input int aw);
		logic [1:0] top;
		top = 2'(a >> (aw - 2));
		unique case (lvl)
			2'h0: return 1'b0;
			2'h1: return top == 2'h3;
			2'h2: return top[1];
			2'h3: return 1'b1;
		endcase
	endfunction
endpackage

/* inc/spi_link_if.sv */
// Serial link between master and memory device
`timescale 1ns/1ps
interface spi_link_if;
	logic csn;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic wp_n;
	modport dev (input csn, input sck, input mosi, input wp_n,
		output miso, output miso_oe);
	modport mst (output csn, output sck, output mosi, output wp_n,
		input miso, input miso_oe);
endinterface

/* hw/link_sync.sv */
// Two-stage synchroniser for link pins
`timescale 1ns/1ps
module link_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	if (W < 1) begin
		$error("link_sync: W must be positive");
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

/* hw/eeprom_dev.sv */
// Memory device end: command engine, array and timed write cycle
`timescale 1ns/1ps
module eeprom_dev import eeprom_pkg::*; #(
	parameter int ADDR_W = ADDR_W_DEF,
	parameter int WC_CYC = WC_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	spi_link_if.dev link,
	output logic busy,
	output logic write_latch_flag,
	output logic [1:0] protect_level
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [8:0] AMASK = 9'((32'd1 << ADDR_W) - 1);
	localparam int WC_W = $clog2(WC_CYC + 1);
	if (ADDR_W < 7 || ADDR_W > 9) begin
		$error("eeprom_dev: ADDR_W 7..9");
	end
	if (WC_CYC < 1) begin
		$error("eeprom_dev: WC_CYC must be positive");
	end
	typedef enum logic [3:0] {
		DS_IDLE, DS_OP, DS_ADDR, DS_RD, DS_SRD, DS_WR, DS_SWR, DS_HOLD,
		DS_MUTE
	} dev_st_e;
	// ****************************************
	// Pin sampling and edges
	// ****************************************
	logic [3:0] syn;
	logic csn_s, sck_s, mosi_s, wp_s;
	logic csn_p_q, sck_p_q;
	logic cs_fall, cs_rise, sck_rise, sck_fall;
	link_sync #(.W(4), .RST(4'h9)) link_sync_inst (
		.clock(clock),
		.rstn(rstn),
		.d({link.csn, link.sck, link.mosi, link.wp_n}),
		.q(syn)
	);
	assign {csn_s, sck_s, mosi_s, wp_s} = syn;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			csn_p_q <= 1'b1;
			sck_p_q <= 1'b0;
		end else begin
			csn_p_q <= csn_s;
			sck_p_q <= sck_s;
		end
	end
	assign cs_fall = csn_p_q & ~csn_s;
	assign cs_rise = ~csn_p_q & csn_s;
	assign sck_rise = ~sck_p_q & sck_s & ~csn_s;
	assign sck_fall = sck_p_q & ~sck_s & ~csn_s;
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] mem [DEPTH];
	logic [1:0] bp_nv = PROT_FACTORY;
	logic [1:0] bp_d;
	logic [7:0] wen;
	logic [8:0] waddr [PAGE_BYTES];
	// ****************************************
	// Command engine
	// ****************************************
	dev_st_e st_q, st_d;
	cmd_e cmd_q, cmd_d, cmd_rx;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, rx;
	logic miso_q, miso_d;
	logic [8:0] addr_q, addr_d, a_rx;
	logic [7:0] pbuf_q [PAGE_BYTES];
	logic [7:0] pbuf_d [PAGE_BYTES];
	logic [7:0] pmask_q, pmask_d;
	logic latch_q, latch_d, busy_q, busy_d, commit;
	logic [WC_W-1:0] wc_q, wc_d;
	logic [7:0] status;
	assign status = {{4{busy_q}}, bp_nv, latch_q, busy_q};
	assign rx = {sh_q[6:0], mosi_s};
	assign cmd_rx = decode_cmd(rx);
	assign a_rx = {addr_q[8], rx} & AMASK;
	always_comb begin
		st_d = st_q;
		cmd_d = cmd_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		miso_d = miso_q;
		addr_d = addr_q;
		pbuf_d = pbuf_q;
		pmask_d = pmask_q;
		latch_d = latch_q;
		busy_d = busy_q;
		wc_d = wc_q;
		bp_d = bp_nv;
		commit = 1'b0;
		if (busy_q) begin
			wc_d = wc_q + 1'b1;
			if (wc_q == WC_W'(WC_CYC - 1)) begin
				busy_d = 1'b0;
				latch_d = 1'b0;
			end
		end
		if (cs_fall) begin
			st_d = DS_OP;
			cnt_d = 3'h0;
			pmask_d = 8'h00;
		end else if (cs_rise) begin
			st_d = DS_IDLE;
			unique case (st_q)
				DS_HOLD: latch_d = cmd_q == CMD_SET;
				DS_WR: begin
					if (cnt_q == 3'h0 && |pmask_q && wp_s) begin
						commit = 1'b1;
						busy_d = 1'b1;
						wc_d = '0;
					end
				end
				DS_SWR: begin
					if (cnt_q == 3'h0 && pmask_q[0] && wp_s) begin
						bp_d = pbuf_q[0][ST_PROT_LSB+:2];
						busy_d = 1'b1;
						wc_d = '0;
					end
				end
				default: ;
			endcase
		end else if (sck_rise) begin
			cnt_d = cnt_q + 1'b1;
			sh_d = rx;
			if (cnt_q == 3'h7) begin
				unique case (st_q)
					DS_OP: begin
						cmd_d = cmd_rx;
						addr_d = {rx[OP_TOP_BIT], 8'h00};
						if (busy_q && cmd_rx != CMD_SRD) begin
							st_d = DS_MUTE;
						end else begin
							unique case (cmd_rx)
								CMD_SET, CMD_CLR: st_d = DS_HOLD;
								CMD_SRD: begin
									st_d = DS_SRD;
									tx_d = status;
								end
								CMD_READ: st_d = DS_ADDR;
								CMD_WRITE: st_d = (latch_q && wp_s)
									? DS_ADDR : DS_MUTE;
								CMD_SWR: st_d = (latch_q && wp_s)
									? DS_SWR : DS_MUTE;
								CMD_BAD: st_d = DS_MUTE;
							endcase
						end
					end
					DS_ADDR: begin
						if (cmd_q == CMD_READ) begin
							st_d = DS_RD;
							tx_d = mem[a_rx[ADDR_W-1:0]];
							addr_d = (a_rx + 9'h001) & AMASK;
						end else begin
							st_d = DS_WR;
							addr_d = a_rx;
						end
					end
					DS_RD: begin
						tx_d = mem[addr_q[ADDR_W-1:0]];
						addr_d = (addr_q + 9'h001) & AMASK;
					end
					DS_SRD: tx_d = status;
					DS_WR: begin
						pbuf_d[addr_q[2:0]] = rx;
						pmask_d[addr_q[2:0]] = 1'b1;
						addr_d = {addr_q[8:3], addr_q[2:0] + 3'h1};
					end
					DS_SWR: begin
						pbuf_d[0] = rx;
						pmask_d[0] = 1'b1;
					end
					default: ;
				endcase
			end
		end else if (sck_fall && (st_q == DS_RD || st_q == DS_SRD)) begin
			miso_d = tx_q[7];
			tx_d = {tx_q[6:0], 1'b0};
		end
		if (!wp_s && !csn_s && (st_q == DS_WR || st_q == DS_SWR
			|| (st_q == DS_ADDR && cmd_q == CMD_WRITE))) begin
			st_d = DS_MUTE;
		end
	end
	always_comb begin
		for (int i = 0; i < PAGE_BYTES; i++) begin
			waddr[i] = {addr_q[8:3], 3'(i)};
			wen[i] = commit && pmask_q[i]
				&& !is_protected(waddr[i], bp_nv, ADDR_W);
		end
	end
	always_ff @(posedge clock) begin
		bp_nv <= bp_d;
		for (int i = 0; i < PAGE_BYTES; i++) begin
			if (wen[i]) begin
				mem[waddr[i][ADDR_W-1:0]] <= pbuf_q[i];
			end
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= DS_IDLE;
			cmd_q <= CMD_BAD;
			cnt_q <= 3'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			miso_q <= 1'b0;
			addr_q <= 9'h000;
			pbuf_q <= '{default: 8'h00};
			pmask_q <= 8'h00;
			latch_q <= 1'b0;
			busy_q <= 1'b0;
			wc_q <= '0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			miso_q <= miso_d;
			addr_q <= addr_d;
			pbuf_q <= pbuf_d;
			pmask_q <= pmask_d;
			latch_q <= latch_d;
			busy_q <= busy_d;
			wc_q <= wc_d;
		end
	end
	assign link.miso = miso_q;
	assign link.miso_oe = st_q == DS_RD || st_q == DS_SRD;
	assign busy = busy_q;
	assign write_latch_flag = latch_q;
	assign protect_level = bp_nv;
endmodule

/* hw/eeprom_host.sv */
// Master end: frames one command, mode 0, clock from a divider
`timescale 1ns/1ps
module eeprom_host import eeprom_pkg::*; #(
	parameter int SCK_HALF = SCK_HALF_CYC,
	parameter int LEN_W = 8
) (
	input wire logic clock,
	input wire logic rstn,
	spi_link_if.mst link,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] addr,
	input wire logic [LEN_W-1:0] len,
	input wire logic [7:0] wr_data,
	input wire logic guard_n,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic ready
);
	localparam int DIV_W = $clog2(SCK_HALF + 1);
	if (SCK_HALF < 4) begin
		$error("eeprom_host: SCK_HALF below 4");
	end
	if (LEN_W < 1) begin
		$error("eeprom_host: LEN_W must be positive");
	end
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HI, H_LO, H_TAIL, H_GAP} host_st_e;
	logic miso_s;
	link_sync #(.W(1), .RST(1'b0)) link_sync_inst (
		.clock(clock),
		.rstn(rstn),
		.d(link.miso),
		.q(miso_s)
	);
	// ****************************************
	// Framing engine
	// ****************************************
	host_st_e st_q, st_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic [2:0] bit_q, bit_d;
	logic [LEN_W:0] byte_q, byte_d, total_q, total_d, hdr_q, hdr_d, nxt;
	logic [7:0] tx_q, tx_d, rx_q, rx_d, addr_q, addr_d, nb;
	logic csn_q, csn_d, sck_q, sck_d, mosi_q, mosi_d, wp_q;
	logic [7:0] rd_q, rd_d;
	logic rdv_q, rdv_d, take_q, take_d, wrap;
	cmd_e c;
	assign wrap = div_q == DIV_W'(SCK_HALF - 1);
	assign c = decode_cmd(opcode);
	assign nxt = byte_q + 1'b1;
	always_comb begin
		st_d = st_q;
		div_d = wrap ? '0 : div_q + 1'b1;
		bit_d = bit_q;
		byte_d = byte_q;
		total_d = total_q;
		hdr_d = hdr_q;
		tx_d = tx_q;
		rx_d = rx_q;
		addr_d = addr_q;
		csn_d = csn_q;
		sck_d = sck_q;
		mosi_d = mosi_q;
		rd_d = rd_q;
		rdv_d = 1'b0;
		take_d = 1'b0;
		nb = (nxt == (LEN_W+1)'(1) && hdr_q == (LEN_W+1)'(2)) ? addr_q : wr_data;
		unique case (st_q)
			H_IDLE: begin
				div_d = '0;
				if (start) begin
					st_d = H_LEAD;
					csn_d = 1'b0;
					tx_d = opcode;
					mosi_d = opcode[7];
					addr_d = addr;
					hdr_d = (c == CMD_READ || c == CMD_WRITE) ? (LEN_W+1)'(2)
						: (LEN_W+1)'(1);
					total_d = hdr_d + {1'b0, len};
					byte_d = '0;
					bit_d = 3'h0;
				end
			end
			H_LEAD, H_LO: if (wrap) begin
				sck_d = 1'b1;
				st_d = H_HI;
			end
			H_HI: if (wrap) begin
				sck_d = 1'b0;
				rx_d = {rx_q[6:0], miso_s};
				bit_d = bit_q + 1'b1;
				st_d = H_LO;
				if (bit_q == 3'h7) begin
					byte_d = nxt;
					if (byte_q >= hdr_q) begin
						rd_d = {rx_q[6:0], miso_s};
						rdv_d = 1'b1;
					end
					if (nxt == total_q) begin
						st_d = H_TAIL;
					end else begin
						tx_d = nb;
						mosi_d = nb[7];
						take_d = nxt >= hdr_q;
					end
				end else begin
					tx_d = {tx_q[6:0], 1'b0};
					mosi_d = tx_q[6];
				end
			end
			H_TAIL: if (wrap) begin
				csn_d = 1'b1;
				st_d = H_GAP;
			end
			H_GAP: if (wrap) st_d = H_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= H_IDLE;
			div_q <= '0;
			bit_q <= 3'h0;
			byte_q <= '0;
			total_q <= '0;
			hdr_q <= '0;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			addr_q <= 8'h00;
			csn_q <= 1'b1;
			sck_q <= 1'b0;
			mosi_q <= 1'b0;
			wp_q <= 1'b1;
			rd_q <= 8'h00;
			rdv_q <= 1'b0;
			take_q <= 1'b0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			total_q <= total_d;
			hdr_q <= hdr_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			addr_q <= addr_d;
			csn_q <= csn_d;
			sck_q <= sck_d;
			mosi_q <= mosi_d;
			wp_q <= guard_n;
			rd_q <= rd_d;
			rdv_q <= rdv_d;
			take_q <= take_d;
		end
	end
	assign link.csn = csn_q;
	assign link.sck = sck_q;
	assign link.mosi = mosi_q;
	assign link.wp_n = wp_q;
	assign rd_data = rd_q;
	assign rd_valid = rdv_q;
	assign wr_take = take_q;
	assign ready = st_q == H_IDLE;
endmodule

/* testbench/eeprom_link_asserts.sv */
// Concurrent checks on the serial link and the device flags
`timescale 1ns/1ps
module eeprom_link_asserts #(
	parameter int WC_CYC = 600
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic csn,
	input wire logic sck,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic wp_n,
	input wire logic busy,
	input wire logic write_latch_flag,
	input wire logic [1:0] protect_level
);
	logic [31:0] bcnt_q, bcnt_d;
	always_comb begin
		bcnt_d = busy ? bcnt_q + 32'h0000_0001 : 32'h0000_0000;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bcnt_q <= 32'h0000_0000;
		end else begin
			bcnt_q <= bcnt_d;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// ****************************************
	// Properties
	// ****************************************
	property p_oe_idle;
		csn [*8] |-> !miso_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("miso driven outside a frame");
	property p_busy_latch;
		$rose(busy) |-> write_latch_flag;
	endproperty
	a_busy_latch: assert property (p_busy_latch)
		else $error("write cycle without latch");
	property p_busy_start;
		$rose(busy) |-> csn && wp_n;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("write cycle not at select release");
	property p_busy_len;
		$fell(busy) |-> bcnt_q >= WC_CYC - 1 && bcnt_q <= WC_CYC + 1;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("write cycle length wrong");
	property p_latch_end;
		$fell(busy) |-> ##[0:2] !write_latch_flag;
	endproperty
	a_latch_end: assert property (p_latch_end)
		else $error("latch kept after write cycle");
	property p_latch_rise;
		$rose(write_latch_flag) |-> csn && !busy;
	endproperty
	a_latch_rise: assert property (p_latch_rise)
		else $error("latch set at wrong time");
	property p_prot_change;
		!$stable(protect_level) |-> ##[0:1] busy;
	endproperty
	a_prot_change: assert property (p_prot_change)
		else $error("protect level changed outside a cycle");
	property p_miso_edge;
		$changed(miso) && $past(miso_oe) && miso_oe |-> !sck;
	endproperty
	a_miso_edge: assert property (p_miso_edge)
		else $error("miso changed while sck high");
	property p_sck_idle;
		csn |-> !sck;
	endproperty
	a_sck_idle: assert property (p_sck_idle)
		else $error("sck high outside a frame");
	c_write: cover property ($rose(busy));
	c_latch: cover property ($rose(write_latch_flag));
	c_prot: cover property (!$stable(protect_level));
	c_read: cover property ($rose(miso_oe));
endmodule

/* testbench/test_spi_eeprom_command_engine.sv */
// Bench: host and device joined over the link, checked from the user side
`timescale 1ns/1ps
module test_spi_eeprom_command_engine import eeprom_pkg::*; ;
	localparam int WC = 600;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [7:0] addr = 8'h00;
	logic [7:0] len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic guard_n = 1'b1;
	logic wr_take, rd_valid, ready, busy, latch;
	logic [7:0] rd_data;
	logic [1:0] prot;
	logic [1:0] prot_m = 2'h0;
	logic [7:0] mem [512];
	logic [8:0] exp_q [$];
	logic [8:0] tgt [3] = '{9'h0FF, 9'h17F, 9'h180};
	int oe_cnt = 0;
	int oe_base = 0;
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;
	spi_link_if spi_link_if_inst ();
	eeprom_host eeprom_host_inst (.clock(clock), .rstn(rstn),
		.link(spi_link_if_inst.mst), .start(start), .opcode(opcode),
		.addr(addr), .len(len), .wr_data(wr_data), .guard_n(guard_n),
		.wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
		.ready(ready));
	eeprom_dev #(.WC_CYC(WC)) eeprom_dev_inst (.clock(clock), .rstn(rstn),
		.link(spi_link_if_inst.dev), .busy(busy),
		.write_latch_flag(latch), .protect_level(prot));
	eeprom_link_asserts #(.WC_CYC(WC)) chk_inst (.clock(clock),
		.rstn(rstn), .csn(spi_link_if_inst.csn), .sck(spi_link_if_inst.sck),
		.miso(spi_link_if_inst.miso), .miso_oe(spi_link_if_inst.miso_oe),
		.wp_n(spi_link_if_inst.wp_n), .busy(busy),
		.write_latch_flag(latch), .protect_level(prot));
	always #5 clock = ~clock;
	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic give_verdict();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check_flags(input logic [3:0] exp);
		cmp_count++;
		if ({prot, latch, busy} !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t flags got %b exp %b", $time,
				{prot, latch, busy}, exp);
		end
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (spi_link_if_inst.miso_oe === 1'b1) begin
			oe_cnt <= oe_cnt + 1;
		end
		if (rd_valid === 1'b1 && exp_q.size() == 0) begin
			check_byte(rd_data, 8'hxx);
		end else if (rd_valid === 1'b1) begin
			if (exp_q[0][8]) begin
				check_byte(rd_data, exp_q[0][7:0]);
			end
			void'(exp_q.pop_front());
		end
		if (cycles == 90000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// ****************************************
	// Stimulus
	// ****************************************
	function automatic logic prot_hit(input logic [8:0] a);
		case (prot_m)
			2'h1: return a >= 9'h180;
			2'h2: return a >= 9'h100;
			2'h3: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	task automatic xfer(input logic [7:0] op, input logic [7:0] ad,
		input int n, input logic [7:0] d0, input logic g);
		int i;
		i = 1;
		@(posedge clock);
		while (ready !== 1'b1) begin
			@(posedge clock);
		end
		start <= 1'b1;
		opcode <= op;
		addr <= ad;
		len <= 8'(n);
		wr_data <= d0;
		guard_n <= g;
		@(posedge clock);
		start <= 1'b0;
		@(posedge clock);
		while (ready !== 1'b1) begin
			if (wr_take === 1'b1) begin
				wr_data <= d0 + 8'(i);
				i++;
			end
			@(posedge clock);
		end
	endtask
	task automatic rd(input logic [8:0] a, input int n);
		for (int k = 0; k < n; k++) begin
			exp_q.push_back({1'b1, mem[9'(a + k)]});
		end
		xfer(OP_READ | {4'h0, a[8], 3'h0}, a[7:0], n, 8'h00, 1'b1);
	endtask
	task automatic stat(input logic [7:0] exp);
		exp_q.push_back({1'b1, exp});
		xfer(OP_STAT_RD, 8'h00, 1, 8'h00, 1'b1);
	endtask
	task automatic prog(input logic [7:0] op, input logic [8:0] a,
		input int n, input logic [7:0] d0, input logic g);
		logic [8:0] p;
		xfer(OP_LATCH_SET, 8'h00, 0, 8'h00, 1'b1);
		for (int k = 0; k < n; k++) begin
			exp_q.push_back(9'h000);
		end
		xfer(op | {4'h0, a[8], 3'h0}, a[7:0], n, d0, g);
		if (!g) begin
			repeat (8) @(posedge clock);
			check_flags({prot_m, 2'b10});
			return;
		end
		if (op == OP_STAT_WR) begin
			prot_m = d0[3:2];
		end
		for (int k = 0; k < n; k++) begin
			p = {a[8:3], 3'(a[2:0] + k)};
			if (op == OP_WRITE && !prot_hit(p)) begin
				mem[p] = d0 + 8'(k);
			end
		end
		check_flags({prot_m, 2'b11});
		xfer(OP_LATCH_CLR, 8'h00, 0, 8'h00, 1'b1);
		stat({4'hF, prot_m, 2'b11});
		while (busy === 1'b1) begin
			@(posedge clock);
		end
		repeat (4) @(posedge clock);
		check_flags({prot_m, 2'b00});
	endtask
	initial begin
		void'($urandom(32'h268f_6294));
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		check_flags(4'h0);
		stat(8'h00);
		exp_q.push_back(9'h000);
		xfer(OP_WRITE, 8'h10, 1, 8'h5A, 1'b1);
		repeat (8) @(posedge clock);
		check_flags(4'h0);
		xfer(OP_LATCH_SET, 8'h00, 0, 8'h00, 1'b1);
		check_flags(4'h2);
		xfer(OP_LATCH_CLR, 8'h00, 0, 8'h00, 1'b0);
		check_flags(4'h0);
		prog(OP_WRITE, 9'h1FF, 1, 8'($urandom), 1'b1);
		prog(OP_WRITE, 9'h006, 4, 8'($urandom), 1'b1);
		rd(9'h1FF, 3);
		rd(9'h006, 2);
		prog(OP_WRITE, 9'h020, 1, 8'($urandom), 1'b0);
		for (int l = 0; l < 4; l++) begin
			prog(OP_STAT_WR, 9'h000, 1, 8'hF3 | 8'(l << 2), 1'b1);
			stat({4'h0, prot_m, 2'b00});
			for (int t = 0; t < 3; t++) begin
				prog(OP_WRITE, tgt[t], 1, 8'($urandom), 1'b1);
			end
			for (int t = 0; t < 3; t++) begin
				rd(tgt[t], 1);
			end
		end
		exp_q.push_back(9'h000);
		oe_base = oe_cnt;
		xfer(8'hF0, 8'h00, 1, 8'h00, 1'b1);
		check_byte(8'(oe_cnt - oe_base), 8'h00);
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		check_flags({prot_m, 2'b00});
		rd(9'h0FF, 1);
		repeat (20) @(posedge clock);
		give_verdict();
	end
endmodule
